// >>> hw/urs_pkg.sv
// Purpose: shared constants for the receiver status output stage
// Assumes: 32-bit AXI4-Lite register access, byte addresses below
// Notes:   status and mask registers share one bit layout
package urs_pkg;
  // -------------------------------------------------------------
  // widths
  // -------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned CHAR_W  = 8;
  localparam int unsigned EVT_W   = 4;

  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h10;

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int unsigned EV_CHAR    = 0;
  localparam int unsigned EV_PARITY  = 1;
  localparam int unsigned EV_FRAMING = 2;
  localparam int unsigned EV_OVERRUN = 3;
  localparam int unsigned CTRL_RDY_CLR = 0;
  localparam int unsigned FL_READY   = 0;
  localparam int unsigned FL_PARITY  = 1;
  localparam int unsigned FL_FRAMING = 2;
  localparam int unsigned FL_OVERRUN = 3;
  localparam int unsigned FL_MODE    = 4;

  // -------------------------------------------------------------
  // reset values and responses
  // -------------------------------------------------------------
  localparam logic [CHAR_W-1:0] HOLD_RST   = 8'h00;
  localparam logic [EVT_W-1:0]  STATUS_RST = 4'h0;
  localparam logic [EVT_W-1:0]  MASK_RST   = 4'h0;
  localparam logic [1:0]        RESP_OKAY  = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;
endpackage

// >>> hw/urs_link_if.sv
// Purpose: carrier between the top and its character and decode helpers
// Assumes: all signals combinational within one clock domain
// Notes:   chk and dec modports face the helper modules
`timescale 1ns/100ps
interface urs_link_if;
  logic [7:0] data;
  logic       parity_bit;
  logic       stop_bit;
  logic       even_sel;
  logic       parity_err;
  logic       framing_err;
  logic       mode_cpu;
  logic       cs_a;
  logic       cs_b_n;
  logic       cs_c;
  logic       rd_wr;
  logic       read_cycle;
  modport chk (input data, parity_bit, stop_bit, even_sel, output parity_err, framing_err);
  modport dec (input mode_cpu, cs_a, cs_b_n, cs_c, rd_wr, output read_cycle);
  modport top (output data, parity_bit, stop_bit, even_sel, mode_cpu, cs_a, cs_b_n, cs_c,
               rd_wr, input parity_err, framing_err, read_cycle);
endinterface

// >>> hw/urs_char_check.sv
// Purpose: parity and stop bit check of one received character
// Assumes: unused high data bits arrive as zero
// Notes:   purely combinational
`timescale 1ns/100ps
module urs_char_check (
  // character in, errors out
  urs_link_if.chk lnk
);
  import urs_pkg::*;

  wire [CHAR_W:0] xor_chain;

  // -------------------------------------------------------------
  // parity accumulation
  // -------------------------------------------------------------
  assign xor_chain[0] = lnk.parity_bit;
  genvar i;
  generate
    for (i = 0; i < CHAR_W; i++) begin : g_xor
      assign xor_chain[i+1] = xor_chain[i] ^ lnk.data[i];
    end
  endgenerate

  // even: ones count incl parity must be even; odd: must be odd
  assign lnk.parity_err  = xor_chain[CHAR_W] ^ ~lnk.even_sel;
  assign lnk.framing_err = ~lnk.stop_bit;
endmodule

// >>> hw/urs_read_decode.sv
// Purpose: processor mode read cycle decode from the chip selects
// Assumes: selects synchronous to clk
// Notes:   never active in standard mode
`timescale 1ns/100ps
module urs_read_decode (
  // selects in, read cycle out
  urs_link_if.dec lnk
);
  import urs_pkg::*;

  wire sel_match;

  assign sel_match      = lnk.cs_a & lnk.cs_c & ~lnk.cs_b_n & lnk.rd_wr;
  assign lnk.read_cycle = lnk.mode_cpu & sel_match;
endmodule

// >>> hw/urs_top.sv
// Purpose: receiver holding register, error flags and bus drivers
// Assumes: receiver shift logic pulses rx_load once per character
// Notes:   three-state pins are split into value and enable
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module urs_top (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // axi4-lite write address
  input  wire logic [urs_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // axi4-lite write data
  input  wire logic [urs_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [urs_pkg::DATA_W/8-1:0]   s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // axi4-lite read
  input  wire logic [urs_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [urs_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // character from receiver shift logic
  input  wire logic                           rx_load,
  input  wire logic [urs_pkg::CHAR_W-1:0]     rx_data,
  input  wire logic                           rx_parity_bit,
  input  wire logic                           rx_stop_bit,
  // control pins
  input  wire logic                           mode_select,
  input  wire logic                           rx_bus_release,
  input  wire logic                           status_output_release,
  input  wire logic                           ready_flag_clear_n,
  input  wire logic                           even_parity_select,
  input  wire logic                           parity_disable,
  input  wire logic                           tx_holding_empty,
  // processor mode selects
  input  wire logic                           chip_sel_a,
  input  wire logic                           chip_sel_b_n,
  input  wire logic                           chip_sel_c,
  input  wire logic                           rd_wr,
  input  wire logic                           register_pick,
  // receive bus
  output logic [urs_pkg::CHAR_W-1:0]          rx_bus_out,
  output logic                                rx_bus_oe,
  // status pins, shared enable
  output logic                                parity_error_flag,
  output logic                                framing_error_flag,
  output logic                                overrun_error_flag,
  output logic                                rx_char_ready,
  output logic                                tx_empty_flag,
  output logic                                status_oe,
  // processor read and interrupt
  output logic                                cpu_read_cycle,
  output logic                                irq
);
  import urs_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [CHAR_W-1:0]   holding;
  logic                ready_q;
  logic                pe_q;
  logic                fe_q;
  logic                oe_q;
  logic [EVT_W-1:0]    status;
  logic [EVT_W-1:0]    mask;
  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   aw_addr_q;
  logic [DATA_W-1:0]   w_data_q;
  logic [DATA_W/8-1:0] w_strb_q;

  urs_link_if lnk ();

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  assign lnk.data       = rx_data;
  assign lnk.parity_bit = rx_parity_bit;
  assign lnk.stop_bit   = rx_stop_bit;
  assign lnk.even_sel   = even_parity_select;
  assign lnk.mode_cpu   = mode_select;
  assign lnk.cs_a       = chip_sel_a;
  assign lnk.cs_b_n     = chip_sel_b_n;
  assign lnk.cs_c       = chip_sel_c;
  assign lnk.rd_wr      = rd_wr;

  urs_char_check u_check (
    .lnk (lnk.chk)
  );

  urs_read_decode u_decode (
    .lnk (lnk.dec)
  );

  // -------------------------------------------------------------
  // register bus decode
  // -------------------------------------------------------------
  wire                wr_en      = aw_held & w_held & ~s_axi_bvalid;
  wire                wr_status  = wr_en & (aw_addr_q == OFS_STATUS) & w_strb_q[0];
  wire                wr_mask    = wr_en & (aw_addr_q == OFS_MASK) & w_strb_q[0];
  wire                wr_ctrl    = wr_en & (aw_addr_q == OFS_CTRL) & w_strb_q[0];
  wire                wr_ro      = (aw_addr_q == OFS_DATA) | (aw_addr_q == OFS_FLAGS);
  wire                wr_hit     = (aw_addr_q == OFS_STATUS) | (aw_addr_q == OFS_MASK) |
                                   (aw_addr_q == OFS_CTRL) | wr_ro;
  wire                sw_rdy_clr = wr_ctrl & w_data_q[CTRL_RDY_CLR];
  wire [EVT_W-1:0]    w1c        = wr_status ? w_data_q[EVT_W-1:0] : '0;
  wire                rd_take    = s_axi_arvalid & ~s_axi_rvalid;
  wire                rd_data    = s_axi_araddr == OFS_DATA;
  wire                rd_status  = s_axi_araddr == OFS_STATUS;
  wire                rd_mask    = s_axi_araddr == OFS_MASK;
  wire                rd_ctrl    = s_axi_araddr == OFS_CTRL;
  wire                rd_flags   = s_axi_araddr == OFS_FLAGS;
  wire                rd_hit     = rd_data | rd_status | rd_mask | rd_ctrl | rd_flags;
  wire [DATA_W-1:0]   flags_word = {27'h0000000, mode_select, oe_q, fe_q, pe_q, ready_q};
  wire [DATA_W-1:0]   next_rdata = rd_data   ? {24'h000000, holding} :
                                   rd_status ? {28'h0000000, status} :
                                   rd_mask   ? {28'h0000000, mask} :
                                   rd_flags  ? flags_word : '0;

  // -------------------------------------------------------------
  // flag next values
  // -------------------------------------------------------------
  wire             pe_calc    = lnk.parity_err & ~parity_disable;
  wire             next_ready = rx_load | (ready_q & ready_flag_clear_n & ~sw_rdy_clr);
  wire [EVT_W-1:0] events     = {rx_load & ready_q, rx_load & lnk.framing_err,
                                 rx_load & pe_calc, rx_load};
  wire [EVT_W-1:0] next_status = (status & ~w1c) | events;
  wire             bus_drive  = mode_select ? (lnk.read_cycle & ~register_pick)
                                            : ~rx_bus_release;

  // -------------------------------------------------------------
  // holding register and error flags
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holding <= HOLD_RST;
      ready_q <= 1'b0;
      pe_q    <= 1'b0;
      fe_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      ready_q <= next_ready;
      if (rx_load) begin
        holding <= rx_data;
        pe_q    <= pe_calc;
        fe_q    <= lnk.framing_err;
        oe_q    <= ready_q;
      end
    end
  end

  // -------------------------------------------------------------
  // status, mask, interrupt
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= STATUS_RST;
      mask   <= MASK_RST;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
      if (wr_mask) begin
        mask <= w_data_q[EVT_W-1:0];
      end
    end
  end

  // -------------------------------------------------------------
  // pin drivers
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_bus_out         <= HOLD_RST;
      rx_bus_oe          <= 1'b0;
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      rx_char_ready      <= 1'b0;
      tx_empty_flag      <= 1'b0;
      status_oe          <= 1'b0;
      cpu_read_cycle     <= 1'b0;
    end else begin
      rx_bus_out         <= holding;
      rx_bus_oe          <= bus_drive;
      parity_error_flag  <= pe_q & ~parity_disable;
      framing_error_flag <= fe_q;
      overrun_error_flag <= oe_q;
      rx_char_ready      <= ready_q;
      tx_empty_flag      <= tx_holding_empty;
      status_oe          <= ~status_output_release;
      cpu_read_cycle     <= lnk.read_cycle;
    end
  end

  // -------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit && !wr_ro) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence char_in_s;
    rx_load && !parity_disable;
  endsequence

  sequence pin_out_s;
    status[EV_OVERRUN] ##1 overrun_error_flag;
  endsequence

  mode0_bus_a: assert property (
    (!mode_select && !rx_bus_release) |=> (rx_bus_oe && rx_bus_out == $past(holding)))
    else $error("standard mode bus not driven");

  bus_release_a: assert property (
    (!mode_select && rx_bus_release) |=> !rx_bus_oe)
    else $error("receive bus not released");

  parity_flag_a: assert property (
    char_in_s |=> pe_q == $past(^rx_data ^ rx_parity_bit ^ ~even_parity_select))
    else $error("parity flag wrong after load");

  framing_flag_a: assert property (
    rx_load |=> fe_q == !$past(rx_stop_bit) ##1 framing_error_flag == $past(fe_q))
    else $error("framing flag wrong after load");

  overrun_flag_a: assert property (
    rx_load |=> oe_q == $past(ready_q) && rx_char_ready == $past(ready_q))
    else $error("overrun flag wrong after load");

  status_float_a: assert property (
    status_output_release |=> !status_oe)
    else $error("status pins not released");

  read_cycle_a: assert property (
    cpu_read_cycle == $past(mode_select && chip_sel_a && chip_sel_c && !chip_sel_b_n && rd_wr))
    else $error("read cycle decode wrong");

  ready_clear_a: assert property (
    (!ready_flag_clear_n && !rx_load) |=> !ready_q ##1 !rx_char_ready)
    else $error("ready flag not cleared");

  parity_clamp_a: assert property (
    parity_disable[*2] |-> !parity_error_flag)
    else $error("parity error not clamped");

  flags_hold_a: assert property (
    !rx_load |=> $stable(pe_q) && $stable(fe_q) && $stable(oe_q))
    else $error("error flag moved without load");

  sticky_set_a: assert property (
    (rx_load && ready_q) |=> pin_out_s)
    else $error("overrun event lost");
endmodule

// >>> bench/urs_host_model.sv
// Purpose: host side pins for processor reads and ready clears
// Assumes: bench requests change just after rising edges
// Notes:   idle pattern leaves the device deselected
`timescale 1ns/100ps
module urs_host_model (
  // clock
  input  wire logic       clk,
  // bench requests
  input  wire logic       sel_en,
  input  wire logic [3:0] sel_code,
  input  wire logic       clr_req,
  // pins toward the device
  output logic            chip_sel_a,
  output logic            chip_sel_b_n,
  output logic            chip_sel_c,
  output logic            rd_wr,
  output logic            ready_flag_clear_n
);
  // ---------------------------------------------------------
  // select pattern and clear pulse
  // ---------------------------------------------------------
  always @(posedge clk) begin
    {chip_sel_a, chip_sel_b_n, chip_sel_c, rd_wr} <= sel_en ? sel_code : 4'h4;
    ready_flag_clear_n <= !clr_req;
  end
endmodule

// >>> bench/uart_rx_status_outputs_tb.sv
// Purpose: random and corner checks of the receiver status stage
// Assumes: seed fixed, inputs change by non-blocking assignment
// Notes:   expectations come from bench code (parity_bad and inline expressions) and from urs_pkg reset and response constants
`timescale 1ns/100ps
module uart_rx_status_outputs_tb;
  import urs_pkg::*;
  // ---------------------------------------------------------
  // signals
  // ---------------------------------------------------------
  logic              clk, rst, rx_load, rx_parity_bit, rx_stop_bit;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rv, rd_v;
  logic [3:0]        s_axi_wstrb, sel_code;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, mode_select, rx_bus_release;
  logic              status_output_release, ready_flag_clear_n, even_parity_select;
  logic              parity_disable, tx_holding_empty, chip_sel_a, chip_sel_b_n;
  logic              chip_sel_c, rd_wr, register_pick, rx_bus_oe, parity_error_flag;
  logic              framing_error_flag, overrun_error_flag, rx_char_ready;
  logic              tx_empty_flag, status_oe, cpu_read_cycle, irq, sel_en, clr_req;
  logic [CHAR_W-1:0] rx_data, rx_bus_out;
  logic              e_rdy, e_pe, e_fe, e_ov, rc;
  logic [6:0]        k;
  integer            fail_count, samples_checked, seed, i;

  urs_top i_urs_top (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_load, .rx_data,
    .rx_parity_bit, .rx_stop_bit, .mode_select, .rx_bus_release, .status_output_release,
    .ready_flag_clear_n, .even_parity_select, .parity_disable, .tx_holding_empty,
    .chip_sel_a, .chip_sel_b_n, .chip_sel_c, .rd_wr, .register_pick, .rx_bus_out,
    .rx_bus_oe, .parity_error_flag, .framing_error_flag, .overrun_error_flag,
    .rx_char_ready, .tx_empty_flag, .status_oe, .cpu_read_cycle, .irq);
  urs_host_model i_urs_host_model (.clk, .sel_en, .sel_code, .clr_req, .chip_sel_a,
    .chip_sel_b_n, .chip_sel_c, .rd_wr, .ready_flag_clear_n);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------
  // compare, report and bus tasks
  // ---------------------------------------------------------
  task automatic check_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) begin
        s_axi_bready <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    fail_count++;
    conclude();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, bh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ah = s_axi_arvalid & s_axi_arready;
      bh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (bh) begin
        s_axi_rready <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    fail_count++;
    conclude();
  endtask
  // ---------------------------------------------------------
  // character load with pin checks
  // ---------------------------------------------------------
  function automatic logic parity_bad(logic [7:0] d, logic p, logic ev, logic dis);
    return dis ? 1'b0 : ((^d) ^ p ^ !ev);
  endfunction
  task automatic send_char(input logic [7:0] d, input logic p, input logic s);
    rx_data <= d;
    rx_parity_bit <= p;
    rx_stop_bit <= s;
    rx_load <= 1'b1;
    @(posedge clk);
    rx_load <= 1'b0;
    e_ov = e_rdy;
    e_rdy = 1'b1;
    e_pe = parity_bad(d, p, even_parity_select, parity_disable);
    e_fe = !s;
    @(posedge clk);
    #1;
    check_bit("parity", e_pe, parity_error_flag);
    check_bit("framing", e_fe, framing_error_flag);
    check_bit("overrun", e_ov, overrun_error_flag);
    check_bit("ready", 1'b1, rx_char_ready);
    check_word("bus", 32'(d), 32'(rx_bus_out));
  endtask
  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    seed = 89002;
    fail_count = 0;
    samples_checked = 0;
    e_rdy = 1'b0;
    rst = 1'b1;
    {rx_load, rx_parity_bit, rx_stop_bit, rx_data} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, sel_en, clr_req, sel_code} = '0;
    {mode_select, rx_bus_release, status_output_release, even_parity_select} = '0;
    {parity_disable, tx_holding_empty, register_pick} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(OFS_STATUS, rd_v, rs);
    check_word("status reset", 32'(STATUS_RST), rd_v);
    axi_rd(OFS_MASK, rd_v, rs);
    check_word("mask reset", 32'(MASK_RST), rd_v);
    for (i = 0; i < 40; i++) begin
      rv = $random(seed);
      even_parity_select <= rv[8];
      parity_disable <= rv[9] & rv[10];
      send_char(rv[7:0], rv[11], rv[12] | rv[13]);
      if (rv[14]) begin
        clr_req <= 1'b1;
        @(posedge clk);
        clr_req <= 1'b0;
        e_rdy = 1'b0;
      end
      repeat (3) @(posedge clk);
      #1;
      check_bit("ready held", e_rdy, rx_char_ready);
      check_bit("parity held", e_pe, parity_error_flag);
      check_bit("framing held", e_fe, framing_error_flag);
      check_bit("overrun held", e_ov, overrun_error_flag);
    end
    rx_data <= 8'hA5;
    rx_load <= 1'b1;
    @(posedge clk);
    rx_data <= 8'h3C;
    @(posedge clk);
    rx_load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check_bit("overrun back to back", 1'b1, overrun_error_flag);
    check_word("bus back to back", 32'h3C, 32'(rx_bus_out));
    e_rdy = 1'b1;
    axi_wr(OFS_STATUS, 32'hF, rs);
    axi_wr(OFS_MASK, 32'h1 << EV_FRAMING, rs);
    send_char(8'h00, 1'b1, 1'b1);
    check_bit("irq masked", 1'b0, irq);
    send_char(8'h00, 1'b1, 1'b0);
    check_bit("irq raised", 1'b1, irq);
    axi_rd(OFS_STATUS, rd_v, rs);
    check_bit("status framing", 1'b1, rd_v[EV_FRAMING]);
    axi_wr(OFS_STATUS, 32'h1 << EV_FRAMING, rs);
    repeat (2) @(posedge clk);
    #1;
    check_bit("irq cleared", 1'b0, irq);
    axi_rd(OFS_DATA, rd_v, rs);
    check_word("data reg", 32'h0, rd_v);
    axi_wr(OFS_DATA, 32'h55, rs);
    check_word("ro write resp", 32'(RESP_SLVERR), 32'(rs));
    axi_rd(8'h20, rd_v, rs);
    check_word("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
    check_word("unmapped data", 32'h0, rd_v);
    axi_wr(OFS_CTRL, 32'h1, rs);
    repeat (2) @(posedge clk);
    #1;
    e_rdy = 1'b0;
    check_bit("ctrl clear", 1'b0, rx_char_ready);
    axi_rd(OFS_FLAGS, rd_v, rs);
    check_word("flags", {27'h0, 1'b0, e_ov, e_fe, e_pe, 1'b0}, rd_v);
    for (i = 0; i < 128; i++) begin
      k = i[6:0];
      mode_select <= k[6];
      rx_bus_release <= k[5];
      register_pick <= k[4];
      sel_code <= k[3:0];
      sel_en <= 1'b1;
      status_output_release <= k[0] ^ k[5];
      tx_holding_empty <= k[1] ^ k[2];
      repeat (3) @(posedge clk);
      #1;
      rc = k[6] & k[3] & !k[2] & k[1] & k[0];
      check_bit("read cycle", rc, cpu_read_cycle);
      check_bit("bus enable", k[6] ? rc & !k[4] : !k[5], rx_bus_oe);
      check_bit("status enable", !(k[0] ^ k[5]), status_oe);
      check_bit("tx empty", k[1] ^ k[2], tx_empty_flag);
    end
    {mode_select, rx_bus_release, status_output_release, sel_en} <= '0;
    send_char(8'h81, 1'b0, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_bit("framing reset", 1'b0, framing_error_flag);
    check_bit("ready reset", 1'b0, rx_char_ready);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(OFS_DATA, rd_v, rs);
    check_word("hold reset", 32'(HOLD_RST), rd_v);
    conclude();
  end
endmodule
